/* periodic_wake_defines.svh */
`ifndef PERIODIC_WAKE_DEFINES_SVH
`define PERIODIC_WAKE_DEFINES_SVH

// Byte offsets on the register bus
`define OFS_STATUS_CONTROL 32'h0000_0000
`define OFS_COUNT_VALUE    32'h0000_0004
`define OFS_MODULO_LIMIT   32'h0000_0008

// Field positions in status_control
`define POS_MATCH_FLAG     7
`define POS_SRC_SEL_HI     6
`define POS_SRC_SEL_LO     5
`define POS_IRQ_ENABLE     4
`define POS_DIV_SEL_HI     3
`define POS_DIV_SEL_LO     0

// Reset values
`define RST_SOURCE_SELECT  2'h0
`define RST_DIVIDER_SELECT 4'h0
`define RST_COUNT_VALUE    8'h00
`define RST_MODULO_LIMIT   8'h00

// Source select codes
`define SRC_LOW_POWER_OSC  2'h0
`define SRC_EXTERNAL_REF   2'h1

// Prescaler divide ratios for codes 1 to 15, low source_select bit clear
`define DIV_LO_01          18'h00008
`define DIV_LO_02          18'h00020
`define DIV_LO_03          18'h00040
`define DIV_LO_04          18'h00080
`define DIV_LO_05          18'h00100
`define DIV_LO_06          18'h00200
`define DIV_LO_07          18'h00400
`define DIV_LO_08          18'h00001
`define DIV_LO_09          18'h00002
`define DIV_LO_0A          18'h00004
`define DIV_LO_0B          18'h0000a
`define DIV_LO_0C          18'h00010
`define DIV_LO_0D          18'h00064
`define DIV_LO_0E          18'h001f4
`define DIV_LO_0F          18'h003e8

// Prescaler divide ratios for codes 1 to 15, low source_select bit set
`define DIV_HI_01          18'h00400
`define DIV_HI_02          18'h00800
`define DIV_HI_03          18'h01000
`define DIV_HI_04          18'h02000
`define DIV_HI_05          18'h04000
`define DIV_HI_06          18'h08000
`define DIV_HI_07          18'h10000
`define DIV_HI_08          18'h003e8
`define DIV_HI_09          18'h007d0
`define DIV_HI_0A          18'h01388
`define DIV_HI_0B          18'h02710
`define DIV_HI_0C          18'h04e20
`define DIV_HI_0D          18'h0c350
`define DIV_HI_0E          18'h186a0
`define DIV_HI_0F          18'h30d40

`endif

/* periodic_wake_pkg.sv */
package periodic_wake_pkg;

	typedef enum logic [1:0] {SEL_NONE, SEL_STATUS, SEL_COUNT, SEL_MODULO} reg_sel_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hsel;
		logic        hready;
		logic [31:0] hwdata;
	} ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} ahb_rsp_t;

	typedef struct packed {
		logic [2:0]  src_prev;
		logic [17:0] div_cnt;
		logic [7:0]  count_value;
		logic [7:0]  modulo_limit;
		logic        match_flag;
		logic [1:0]  source_select;
		logic        match_irq_enable;
		logic [3:0]  divider_select;
		logic        irq;
		logic        wr_pend;
		reg_sel_t    wr_sel;
		logic [31:0] hrdata;
		logic        hreadyout;
	} wake_state_t;

endpackage : periodic_wake_pkg

/* periodic_wake_counter.sv */
// Local design decisions: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "periodic_wake_defines.svh"
// Notes on behaviour
// - Counter wrapping from modulo back to zero sets match_flag, bit 7 of status_control.
// - Writing 1 clears flag and pending request; writing 0 does nothing; reset clears.
// - source_select bits 6:5: 00 low-power osc, 01 external, 1x internal; reset clears.
// - Changing source_select clears prescaler divider and count.
// - match_irq_enable bit 4 gates flag onto irq; clear means polling; reset clears.
// - divider_select bits 3:0 with source_select[0] picks ratio; zero stops prescaler.
// - Codes 1..15 look up the ratio in the table picked by source_select[0]; each table is binary for 1..7, mostly decimal for 8..15.
// - Writing a different divider_select clears prescaler divider and count.
// - count_value is readable and ignores writes.
// - Count zeroes on reset, modulo write, or changed select field write.
// - Compare match returns count to zero and sets match_flag.
// - Modulo zero sets match_flag on every prescaler output tick.
// - Any modulo write clears prescaler divider and count.
// - modulo_limit is eight read/write bits, zero after reset.
// - Count advances by one per prescaler tick until it equals modulo.
// - Flag sets on the tick taking count from modulo back to zero.
// - After reset the counter stays halted until a nonzero divider_select.
module periodic_wake_counter
(
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire periodic_wake_pkg::ahb_req_t ahb_req,
	output      periodic_wake_pkg::ahb_rsp_t ahb_rsp,
	input  wire logic                      low_power_osc_1khz,
	input  wire logic                      external_ref_clock,
	input  wire logic                      internal_ref_clock,
	output      logic                      irq
);
	import periodic_wake_pkg::*;

	wake_state_t st_ff;
	wake_state_t nxt_st;
	logic        tick;
	logic        match;
	logic        clr;
	logic        sc_wr;
	logic        mod_wr;
	logic        src_edge;

	function automatic reg_sel_t decode(input logic [31:0] a);
		if (a == `OFS_STATUS_CONTROL)
			decode = SEL_STATUS;
		else if (a == `OFS_COUNT_VALUE)
			decode = SEL_COUNT;
		else if (a == `OFS_MODULO_LIMIT)
			decode = SEL_MODULO;
		else
			decode = SEL_NONE;
	endfunction : decode

	// Divide ratio, table by source_select[0]
	function automatic logic [17:0] ratio(input logic hi, input logic [3:0] ps);
		ratio = 18'h00001;
		case ({hi, ps})
			5'h01: ratio = `DIV_LO_01;
			5'h02: ratio = `DIV_LO_02;
			5'h03: ratio = `DIV_LO_03;
			5'h04: ratio = `DIV_LO_04;
			5'h05: ratio = `DIV_LO_05;
			5'h06: ratio = `DIV_LO_06;
			5'h07: ratio = `DIV_LO_07;
			5'h08: ratio = `DIV_LO_08;
			5'h09: ratio = `DIV_LO_09;
			5'h0a: ratio = `DIV_LO_0A;
			5'h0b: ratio = `DIV_LO_0B;
			5'h0c: ratio = `DIV_LO_0C;
			5'h0d: ratio = `DIV_LO_0D;
			5'h0e: ratio = `DIV_LO_0E;
			5'h0f: ratio = `DIV_LO_0F;
			5'h11: ratio = `DIV_HI_01;
			5'h12: ratio = `DIV_HI_02;
			5'h13: ratio = `DIV_HI_03;
			5'h14: ratio = `DIV_HI_04;
			5'h15: ratio = `DIV_HI_05;
			5'h16: ratio = `DIV_HI_06;
			5'h17: ratio = `DIV_HI_07;
			5'h18: ratio = `DIV_HI_08;
			5'h19: ratio = `DIV_HI_09;
			5'h1a: ratio = `DIV_HI_0A;
			5'h1b: ratio = `DIV_HI_0B;
			5'h1c: ratio = `DIV_HI_0C;
			5'h1d: ratio = `DIV_HI_0D;
			5'h1e: ratio = `DIV_HI_0E;
			5'h1f: ratio = `DIV_HI_0F;
			default: ratio = 18'h00001;
		endcase
	endfunction : ratio

	function automatic logic [31:0] read_mux(input wake_state_t s, input reg_sel_t sel);
		read_mux = 32'h0000_0000;
		if (sel == SEL_STATUS)
			read_mux[7:0] = {s.match_flag, s.source_select, s.match_irq_enable,
				s.divider_select};
		else if (sel == SEL_COUNT)
			read_mux[7:0] = s.count_value;
		else if (sel == SEL_MODULO)
			read_mux[7:0] = s.modulo_limit;
	endfunction : read_mux

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.src_prev = {internal_ref_clock, external_ref_clock, low_power_osc_1khz};
		nxt_st.hreadyout = 1'b1;
		sc_wr = st_ff.wr_pend && (st_ff.wr_sel == SEL_STATUS);
		mod_wr = st_ff.wr_pend && (st_ff.wr_sel == SEL_MODULO);

		// Input sources are sampled levels; a rising edge is one cycle high-after-low
		if (st_ff.source_select == `SRC_LOW_POWER_OSC)
			src_edge = low_power_osc_1khz && !st_ff.src_prev[0];
		else if (st_ff.source_select == `SRC_EXTERNAL_REF)
			src_edge = external_ref_clock && !st_ff.src_prev[1];
		else
			src_edge = internal_ref_clock && !st_ff.src_prev[2];

		// Prescaler; code zero keeps it and the counter halted
		tick = 1'b0;
		if (st_ff.divider_select != 4'h0 && src_edge)
		begin
			if (st_ff.div_cnt >= ratio(st_ff.source_select[0], st_ff.divider_select)
				- 18'h00001)
			begin
				nxt_st.div_cnt = 18'h00000;
				tick = 1'b1;
			end
			else
				nxt_st.div_cnt = st_ff.div_cnt + 18'h00001;
		end

		match = tick && (st_ff.count_value == st_ff.modulo_limit);
		if (match)
			nxt_st.count_value = 8'h00;
		else if (tick)
			nxt_st.count_value = st_ff.count_value + 8'h01;

		// Software clear of the flag; a match in the same cycle still sets it
		if (sc_wr && ahb_req.hwdata[`POS_MATCH_FLAG])
			nxt_st.match_flag = 1'b0;
		if (match)
			nxt_st.match_flag = 1'b1;

		clr = 1'b0;
		if (sc_wr)
		begin
			if (ahb_req.hwdata[`POS_SRC_SEL_HI:`POS_SRC_SEL_LO] != st_ff.source_select)
				clr = 1'b1;
			if (ahb_req.hwdata[`POS_DIV_SEL_HI:`POS_DIV_SEL_LO] != st_ff.divider_select)
				clr = 1'b1;
			nxt_st.source_select = ahb_req.hwdata[`POS_SRC_SEL_HI:`POS_SRC_SEL_LO];
			nxt_st.match_irq_enable = ahb_req.hwdata[`POS_IRQ_ENABLE];
			nxt_st.divider_select = ahb_req.hwdata[`POS_DIV_SEL_HI:`POS_DIV_SEL_LO];
		end
		if (mod_wr)
		begin
			nxt_st.modulo_limit = ahb_req.hwdata[7:0];
			clr = 1'b1;
		end
		// Writes to count_value fall through untouched
		if (clr)
		begin
			nxt_st.div_cnt = 18'h00000;
			nxt_st.count_value = `RST_COUNT_VALUE;
		end

		nxt_st.irq = nxt_st.match_flag && nxt_st.match_irq_enable;

		// Zero-wait slave; read data comes from the post-update state so that a read
		// right behind a write sees the written value
		nxt_st.wr_pend = 1'b0;
		if (ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1])
		begin
			nxt_st.wr_pend = ahb_req.hwrite;
			nxt_st.wr_sel = decode(ahb_req.haddr);
			if (!ahb_req.hwrite)
				nxt_st.hrdata = read_mux(nxt_st, decode(ahb_req.haddr));
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff.src_prev <= 3'h0;
			st_ff.div_cnt <= 18'h00000;
			st_ff.count_value <= `RST_COUNT_VALUE;
			st_ff.modulo_limit <= `RST_MODULO_LIMIT;
			st_ff.match_flag <= 1'b0;
			st_ff.source_select <= `RST_SOURCE_SELECT;
			st_ff.match_irq_enable <= 1'b0;
			st_ff.divider_select <= `RST_DIVIDER_SELECT;
			st_ff.irq <= 1'b0;
			st_ff.wr_pend <= 1'b0;
			st_ff.wr_sel <= SEL_NONE;
			st_ff.hrdata <= 32'h0000_0000;
			st_ff.hreadyout <= 1'b1;
		end
		else
			st_ff <= nxt_st;
	end

	assign ahb_rsp.hrdata = st_ff.hrdata;
	assign ahb_rsp.hreadyout = st_ff.hreadyout;
	assign ahb_rsp.hresp = 1'b0;
	assign irq = st_ff.irq;

	sequence match_tick_s;
		tick && (st_ff.count_value == st_ff.modulo_limit);
	endsequence

	sequence flag_clear_s;
		sc_wr && ahb_req.hwdata[7] && !match;
	endsequence

	flag_on_match_a: assert property (@(posedge clk) disable iff (!rstn)
		match_tick_s |=> st_ff.match_flag && st_ff.count_value == 8'h00 || $past(clr))
		else $error("match did not set flag and wrap count");

	flag_w1c_a: assert property (@(posedge clk) disable iff (!rstn)
		flag_clear_s |=> !st_ff.match_flag && !irq)
		else $error("write one did not clear flag");

	flag_w0_keep_a: assert property (@(posedge clk) disable iff (!rstn)
		sc_wr && !ahb_req.hwdata[7] && st_ff.match_flag |=> st_ff.match_flag)
		else $error("write zero changed flag");

	irq_gate_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.match_flag && st_ff.match_irq_enable && !sc_wr |=> irq ##0 st_ff.match_flag)
		else $error("enabled flag gave no interrupt");

	irq_mask_a: assert property (@(posedge clk) disable iff (!rstn)
		!st_ff.match_irq_enable |-> !irq)
		else $error("interrupt while disabled");

	sel_change_a: assert property (@(posedge clk) disable iff (!rstn)
		sc_wr && ahb_req.hwdata[6:0] != {st_ff.source_select, st_ff.match_irq_enable,
			st_ff.divider_select} && ahb_req.hwdata[4] == st_ff.match_irq_enable
		|=> st_ff.count_value == 8'h00 && st_ff.div_cnt == 18'h00000)
		else $error("select change did not clear counters");

	mod_write_a: assert property (@(posedge clk) disable iff (!rstn)
		mod_wr |=> st_ff.count_value == 8'h00 && st_ff.div_cnt == 18'h00000
			&& st_ff.modulo_limit == $past(ahb_req.hwdata[7:0]))
		else $error("modulo write mishandled");

	halt_off_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.divider_select == 4'h0 && !clr |=> $stable(st_ff.count_value))
		else $error("counter moved while prescaler off");

	count_step_a: assert property (@(posedge clk) disable iff (!rstn)
		tick && !match && !clr |=> st_ff.count_value == $past(st_ff.count_value) + 8'h01)
		else $error("count did not step by one");

	mod_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		tick && st_ff.modulo_limit == 8'h00 |=> st_ff.match_flag)
		else $error("zero modulo tick did not set flag");

	div_one_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.source_select == 2'h2 && st_ff.divider_select == 4'h8
		&& internal_ref_clock && !st_ff.src_prev[2] |-> tick)
		else $error("internal edge at ratio one gave no tick");

	div_eight_a: assert property (@(posedge clk) disable iff (!rstn)
		tick && st_ff.source_select == 2'h0 && st_ff.divider_select == 4'h1
		|-> st_ff.div_cnt == 18'h00007)
		else $error("ratio eight miscounted");

	// Routing checks: only the selected source may move the prescaler
	src_low_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.source_select == 2'h0 && st_ff.divider_select == 4'h8
		&& low_power_osc_1khz && !st_ff.src_prev[0] |-> tick)
		else $error("low power edge at ratio one gave no tick");

	src_low_only_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.source_select == 2'h0 && !(low_power_osc_1khz && !st_ff.src_prev[0])
		|-> !tick)
		else $error("tick without low power edge");

	src_ext_only_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.source_select == 2'h1 && !(external_ref_clock && !st_ff.src_prev[1])
		|-> !tick)
		else $error("tick without external edge");

	src_int_only_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.source_select[1] && !(internal_ref_clock && !st_ff.src_prev[2])
		|-> !tick)
		else $error("tick without internal edge");

	src_write_a: assert property (@(posedge clk) disable iff (!rstn)
		sc_wr |=> st_ff.source_select == $past(ahb_req.hwdata[6:5]))
		else $error("source select not written");

	off_no_tick_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.divider_select == 4'h0 |-> !tick)
		else $error("tick while prescaler off");

	// A wrong table entry shows up as a tick at the wrong divider count
	div_two_a: assert property (@(posedge clk) disable iff (!rstn)
		tick && st_ff.source_select == 2'h0 && st_ff.divider_select == 4'h9
		|-> st_ff.div_cnt == 18'h00001)
		else $error("ratio two miscounted");

	div_thousand_a: assert property (@(posedge clk) disable iff (!rstn)
		tick && st_ff.source_select == 2'h1 && st_ff.divider_select == 4'h8
		|-> st_ff.div_cnt == 18'h003e7)
		else $error("ratio thousand miscounted");

	div_bound_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.divider_select != 4'h0
		|-> st_ff.div_cnt < ratio(st_ff.source_select[0], st_ff.divider_select))
		else $error("prescaler count beyond ratio");

	count_ro_a: assert property (@(posedge clk) disable iff (!rstn)
		st_ff.wr_pend && st_ff.wr_sel == SEL_COUNT && !tick |=> $stable(st_ff.count_value))
		else $error("write reached the count");

	count_read_a: assert property (@(posedge clk) disable iff (!rstn)
		ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite
		&& ahb_req.haddr == `OFS_COUNT_VALUE |=> ahb_rsp.hrdata == {24'h0, st_ff.count_value})
		else $error("count read incoherent");

	clr_zero_a: assert property (@(posedge clk) disable iff (!rstn)
		clr |=> st_ff.count_value == 8'h00 && st_ff.div_cnt == 18'h00000)
		else $error("clear left counters running");

	flag_no_spurious_a: assert property (@(posedge clk) disable iff (!rstn)
		!st_ff.match_flag && !match |=> !st_ff.match_flag)
		else $error("flag set without match");

	irq_only_flag_a: assert property (@(posedge clk) disable iff (!rstn)
		irq |-> st_ff.match_flag && st_ff.match_irq_enable)
		else $error("interrupt without enabled flag");

	enable_write_a: assert property (@(posedge clk) disable iff (!rstn)
		sc_wr |=> st_ff.match_irq_enable == $past(ahb_req.hwdata[4]))
		else $error("interrupt enable not written");

	mod_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		!mod_wr |=> $stable(st_ff.modulo_limit))
		else $error("modulo changed without write");

endmodule : periodic_wake_counter

/* periodic_wake_counter_tb.sv */
`timescale 1ns/1ps
`include "periodic_wake_defines.svh"
module periodic_wake_counter_tb;
	import periodic_wake_pkg::*;
	logic        clk;
	logic        rstn;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic [2:0]  src;
	logic        irq;
	ahb_req_t    ahb_req;
	ahb_rsp_t    ahb_rsp;
	int          fail_count;
	int          samples_checked;
	localparam logic [31:0] SC = `OFS_STATUS_CONTROL;
	localparam logic [31:0] CV = `OFS_COUNT_VALUE;
	localparam logic [31:0] ML = `OFS_MODULO_LIMIT;

	// Single slave, so its own hreadyout closes the loop as bus hready
	assign ahb_req = '{haddr: haddr, htrans: htrans, hwrite: hwrite, hsize: 3'h2,
		hsel: 1'b1, hready: ahb_rsp.hreadyout, hwdata: hwdata};

	periodic_wake_counter periodic_wake_counter_i
	(
		.clk                (clk),
		.rstn               (rstn),
		.ahb_req            (ahb_req),
		.ahb_rsp            (ahb_rsp),
		.low_power_osc_1khz (src[0]),
		.external_ref_clock (src[1]),
		.internal_ref_clock (src[2]),
		.irq                (irq)
	);

	always #12.5 clk = ~clk;

	task end_sim;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// Bounded wait for hready; an endless stall would hang the run
	task wait_ready;
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ahb_rsp.hreadyout !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fail_count++;
			end_sim();
		end
	endtask : wait_ready

	task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= d;
		wait_ready();
		r = ahb_rsp.hrdata;
	endtask : bus

	task wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		bus(1'b1, a, {24'h0, d}, r);
	endtask : wr

	task rd(input string name, input logic [31:0] a, input logic [7:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(name, r, {24'h0, exp});
	endtask : rd

	// Slow square edges on one source, several bus clocks per level
	task edges(input int k, input int n);
		repeat (n)
		begin
			@(posedge clk);
			src[k] <= 1'b1;
			repeat (2) @(posedge clk);
			src[k] <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : edges

	task reset_values;
		chk("irq", {31'h0, irq}, 32'h0);
		rd("status", SC, 8'h00);
		rd("count", CV, 8'h00);
		rd("modulo", ML, 8'h00);
		rd("unmapped", 32'hc, 8'h00);
		edges(0, 6);
		rd("halted", CV, 8'h00);
		rd("halted flag", SC, 8'h00);
	endtask : reset_values

	task match_and_irq;
		wr(ML, 8'h03);
		rd("modulo rw", ML, 8'h03);
		wr(SC, 8'h18);
		edges(0, 2);
		rd("count up", CV, 8'h02);
		wr(CV, 8'h55);
		rd("count ro", CV, 8'h02);
		edges(0, 1);
		rd("at modulo", CV, 8'h03);
		chk("no irq yet", {31'h0, irq}, 32'h0);
		edges(0, 1);
		rd("wrapped", CV, 8'h00);
		rd("flag set", SC, 8'h98);
		chk("irq on", {31'h0, irq}, 32'h1);
		wr(SC, 8'h18);
		rd("w0 keeps", SC, 8'h98);
		wr(SC, 8'h08);
		rd("flag polled", SC, 8'h88);
		chk("irq masked", {31'h0, irq}, 32'h0);
		wr(SC, 8'h98);
		rd("w1 clears", SC, 8'h18);
		chk("irq off", {31'h0, irq}, 32'h0);
	endtask : match_and_irq

	task ratios_and_clears;
		edges(0, 2);
		wr(SC, 8'h09);
		rd("div change", CV, 8'h00);
		edges(0, 5);
		rd("ratio 2", CV, 8'h02);
		wr(ML, 8'h10);
		rd("mod write", CV, 8'h00);
		edges(0, 1);
		rd("prescaler cleared", CV, 8'h00);
		wr(SC, 8'h28);
		rd("src change", CV, 8'h00);
		edges(0, 3);
		edges(1, 999);
		rd("ext 999", CV, 8'h00);
		edges(1, 1);
		rd("ext 1000", CV, 8'h01);
		wr(SC, 8'h48);
		rd("int src", CV, 8'h00);
		edges(2, 3);
		rd("int ratio 1", CV, 8'h03);
		wr(SC, 8'h68);
		rd("src 11", CV, 8'h00);
	endtask : ratios_and_clears

	task modulo_zero;
		wr(SC, 8'h48);
		wr(ML, 8'h00);
		edges(2, 1);
		rd("mod0 flag", SC, 8'hc8);
		wr(SC, 8'hc8);
		rd("mod0 clr", SC, 8'h48);
		edges(2, 1);
		rd("mod0 again", SC, 8'hc8);
		rd("mod0 count", CV, 8'h00);
		wr(ML, 8'h05);
		wr(SC, 8'h40);
		edges(2, 2);
		rd("off", CV, 8'h00);
	endtask : modulo_zero

	// Reset in mid-run with flag, enable, modulo and count all nonzero
	task mid_reset;
		wr(SC, 8'h58);
		edges(2, 2);
		chk("irq before reset", {31'h0, irq}, 32'h1);
		rd("count before reset", CV, 8'h02);
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		chk("irq reset", {31'h0, irq}, 32'h0);
		rd("status reset", SC, 8'h00);
		rd("count reset", CV, 8'h00);
		rd("modulo reset", ML, 8'h00);
		wr(SC, 8'h01);
		edges(0, 7);
		rd("ratio 8 early", SC, 8'h01);
		edges(0, 1);
		rd("ratio 8 tick", SC, 8'h81);
	endtask : mid_reset

	initial
	begin
		clk = 1'b0;
		rstn = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		src = 3'h0;
		fail_count = 0;
		samples_checked = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		reset_values();
		match_and_irq();
		ratios_and_clears();
		modulo_zero();
		mid_reset();
		end_sim();
	end
endmodule : periodic_wake_counter_tb
